// ---- rtl/xip_ctrl.sv ----
/*
 * Extra external interrupts, eight-source priority resolver and nibble port.
 * Holds the extra control register and the auxiliary port; reads the core's
 * enable, priority and request bits for the standard sources as inputs.
 * Assumes one special-function access per cycle from the core, and that the
 * core raises vec_ack for one cycle when it enters the vector it was given,
 * and ret_ack for one cycle on return from an interrupt routine.
 */
`timescale 1ns/1ps
module xip_ctrl
	import xip_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic sfr_bit,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_bit_val,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire logic global_enable,
	input wire logic [5:0] std_enable,
	input wire logic [5:0] std_priority,
	input wire logic [5:0] std_request,
	input wire logic vec_ack,
	input wire logic ret_ack,
	output logic irq_req,
	output logic [7:0] irq_vector,
	output logic [2:0] irq_source,
	input wire logic [3:0] port_in,
	output logic [3:0] port_out,
	output logic [3:0] port_oe
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] bit_target(input logic [7:0] base, input logic [7:0] a);
		bit_target = {a[7:3], 3'h0} ^ base;
	endfunction

	function automatic logic [2:0] first_set(input logic [XIP_NSRC-1:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = XIP_NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		first_set = r;
	endfunction

	// ------------------------------------------------------------
	// Register access decode
	// ------------------------------------------------------------
	logic [7:0] xctl_q;
	logic [7:0] xctl_d;
	logic [3:0] port_q;
	logic [3:0] port_d;
	logic [3:0] drive_q;
	logic [3:0] drive_d;
	xip_level_type run_q [0:1];
	logic [1:0] active_q;
	logic [1:0] active_d;

	wire xctl_sel = sfr_bit ? (bit_target(XIP_ADDR_XCTL, sfr_addr) == 8'h00) :
		(sfr_addr == XIP_ADDR_XCTL);
	wire port_sel = sfr_bit ? (bit_target(XIP_ADDR_PORT, sfr_addr) == 8'h00) :
		(sfr_addr == XIP_ADDR_PORT);
	wire [2:0] bit_idx = sfr_addr[2:0];
	wire xctl_wr = sfr_wr & xctl_sel;
	wire port_wr = sfr_wr & port_sel;

	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	logic [3:0] pin_level;
	logic [3:0] pin_fall;

	genvar g;
	generate
		for (g = 0; g < XIP_PORT_PINS; g++) begin : g_sync
			xip_pin_sync u_sync (
				.core_clk(core_clk),
				.rst_b(rst_b),
				.pin_in(port_in[g]),
				.pin_level(pin_level[g]),
				.pin_fall(pin_fall[g])
			);
		end
	endgenerate

	// port bits 3 and 2 are the request pins
	wire a_low = ~pin_level[XIP_PIN_A];
	wire b_low = ~pin_level[XIP_PIN_B];
	wire a_fall = pin_fall[XIP_PIN_A];
	wire b_fall = pin_fall[XIP_PIN_B];

	// ------------------------------------------------------------
	// Request gathering and resolution
	// ------------------------------------------------------------
	// edge uses the pending flag, level uses the pin
	wire a_req = xctl_q[XIP_A_TYPE] ? xctl_q[XIP_A_PEND] : a_low;
	wire b_req = xctl_q[XIP_B_TYPE] ? xctl_q[XIP_B_PEND] : b_low;

	// gate each request by its enable
	wire [XIP_NSRC-1:0] enabled = {b_req & xctl_q[XIP_B_EN], a_req & xctl_q[XIP_A_EN],
		std_request & std_enable} & {XIP_NSRC{global_enable}};
	// standard priority bits taken from the core
	wire [XIP_NSRC-1:0] prio = {xctl_q[XIP_B_PRIO], xctl_q[XIP_A_PRIO], std_priority};
	wire [XIP_NSRC-1:0] hi_set = enabled & prio;
	wire [XIP_NSRC-1:0] lo_set = enabled & ~prio;

	// high pre-empts low; nothing pre-empts high
	wire hi_ok = ~active_q[1] & (|hi_set);
	wire lo_ok = ~active_q[1] & ~active_q[0] & (|lo_set);
	// lowest set position wins within a level
	// extra A polled at position 6
	wire [2:0] src = hi_ok ? first_set(hi_set) : first_set(lo_set);
	wire [7:0] vec = XIP_VEC_EXT0 + 8'({src, 3'h0});

	assign irq_req = hi_ok | lo_ok;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_vector <= XIP_VEC_EXT0;
			irq_source <= 3'h0;
		end else begin
			irq_vector <= vec;
			irq_source <= src;
		end
	end

	// ------------------------------------------------------------
	// Service level tracking
	// ------------------------------------------------------------
	wire take = vec_ack & irq_req;
	wire take_hi = take & hi_ok;

	always_comb begin
		active_d = active_q;
		if (ret_ack) begin
			if (active_q[1]) begin
				active_d[1] = 1'b0;
			end else begin
				active_d[0] = 1'b0;
			end
		end
		if (take) begin
			active_d[take_hi ? 1 : 0] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			active_q <= 2'b00;
			run_q[0] <= XIP_LVL_NONE;
			run_q[1] <= XIP_LVL_NONE;
		end else begin
			active_q <= active_d;
			run_q[0] <= active_d[0] ? XIP_LVL_LOW : XIP_LVL_NONE;
			run_q[1] <= active_d[1] ? XIP_LVL_HIGH : XIP_LVL_NONE;
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_comb begin
		xctl_d = xctl_q;
		if (xctl_wr) begin
			if (sfr_bit) begin
				xctl_d[bit_idx] = sfr_bit_val;
			end else begin
				xctl_d = sfr_wdata;
			end
		end
		// clear pending on vector in edge mode
		if (take && src == XIP_POS_A && xctl_q[XIP_A_TYPE]) begin
			xctl_d[XIP_A_PEND] = 1'b0;
		end
		if (take && src == XIP_POS_B && xctl_q[XIP_B_TYPE]) begin
			xctl_d[XIP_B_PEND] = 1'b0;
		end
		// falling edge sets pending; set wins over clear
		// same flag behaviour as standard externals
		if (a_fall && xctl_d[XIP_A_TYPE]) begin
			xctl_d[XIP_A_PEND] = 1'b1;
		end
		if (b_fall && xctl_d[XIP_B_TYPE]) begin
			xctl_d[XIP_B_PEND] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			xctl_q <= XIP_RESET_XCTL;
		end else begin
			xctl_q <= xctl_d;
		end
	end

	// ------------------------------------------------------------
	// Auxiliary nibble port
	// ------------------------------------------------------------
	always_comb begin
		port_d = port_q;
		if (port_wr) begin
			if (sfr_bit) begin
				if (bit_idx < 3'(XIP_PORT_PINS)) begin
					port_d[bit_idx[1:0]] = sfr_bit_val;
				end
			end else begin
				port_d = sfr_wdata[3:0];
			end
		end
	end

	// A one-cycle strong high speeds the 0->1 edge, then the pull-up holds it
	always_comb begin
		drive_d = ~port_d | (port_d & ~port_q);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_q <= XIP_RESET_PORT;
			drive_q <= 4'h0;
		end else begin
			port_q <= port_d;
			drive_q <= drive_d;
		end
	end

	// released pins rely on the pull-up to read high
	assign port_out = port_q;
	assign port_oe = drive_q;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// byte read returns pin levels; bit reads return latch
	wire [7:0] port_rd = sfr_bit ? {4'h0, port_q} : {4'h0, pin_level};
	wire [7:0] rd_mux = xctl_sel ? xctl_q : (port_sel ? port_rd : 8'h00);

	assign sfr_hit = xctl_sel | port_sel;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= rd_mux;
		end
	end
endmodule

// ---- rtl/xip_pin_sync.sv ----
/*
 * Three-stage pin synchroniser for one input.
 * Assumes the pin is asynchronous to core_clk.
 */
`timescale 1ns/1ps
module xip_pin_sync
	import xip_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic pin_in,
	output logic pin_level,
	output logic pin_fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;

	// A change counts once stages two and three agree; stage one feeds stage two only
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			lvl_q <= 1'b1;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end

	assign pin_level = lvl_q;
	assign pin_fall = lvl_q & (s2_q == s3_q) & ~s3_q;
endmodule

// ---- rtl/xip_pkg.sv ----
/*
 * Package for the extra external interrupt and nibble port block.
 * Assumes a core that issues byte and bit special-function accesses on core_clk.
 */
package xip_pkg;
	// ------------------------------------------------------------
	// Special-function addresses
	// ------------------------------------------------------------
	localparam logic [7:0] XIP_ADDR_XCTL = 8'hc0;
	localparam logic [7:0] XIP_ADDR_PORT = 8'hd8;
	localparam logic [7:0] XIP_RESET_XCTL = 8'h00;
	localparam logic [3:0] XIP_RESET_PORT = 4'hf;
	localparam int XIP_PORT_PINS = 4;

	// ------------------------------------------------------------
	// Control register field positions
	// ------------------------------------------------------------
	localparam int XIP_A_TYPE = 0;
	localparam int XIP_A_PEND = 1;
	localparam int XIP_A_EN = 2;
	localparam int XIP_A_PRIO = 3;
	localparam int XIP_B_TYPE = 4;
	localparam int XIP_B_PEND = 5;
	localparam int XIP_B_EN = 6;
	localparam int XIP_B_PRIO = 7;
	localparam int XIP_PIN_A = 2;
	localparam int XIP_PIN_B = 3;

	// ------------------------------------------------------------
	// Vectors, indexed by polling position
	// ------------------------------------------------------------
	localparam int XIP_NSRC = 8;
	localparam logic [7:0] XIP_VEC_EXT0 = 8'h03;
	localparam logic [7:0] XIP_VEC_STEP = 8'h08;
	localparam logic [2:0] XIP_POS_A = 3'h6;
	localparam logic [2:0] XIP_POS_B = 3'h7;

	typedef enum logic [1:0] {
		XIP_LVL_NONE = 2'b00,
		XIP_LVL_LOW = 2'b01,
		XIP_LVL_HIGH = 2'b10
	} xip_level_type;
endpackage

// ---- tb/testbench.sv ----
/* Directed bench for xip_ctrl.
   Assumes the pin model as far side and a core modelled by tasks. */
`timescale 1ns/1ps
module testbench
	import xip_pkg::*;
;
	logic core_clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, sfr_bit = 0, sfr_bit_val = 0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, irq_vector;
	logic sfr_hit, global_enable = 0, vec_ack = 0, ret_ack = 0, irq_req;
	logic [5:0] std_enable = 6'h00, std_priority = 6'h00, std_request = 6'h00;
	logic [2:0] irq_source;
	logic [3:0] port_in, port_out, port_oe, dev_low = 4'h0;
	int bad_count = 0, check_count = 0, cyc = 0;
	// ----
	// Clock, timeout, instances
	// ----
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			end_of_test();
		end
	end
	xip_ctrl xip_ctrl_i (.core_clk, .rst_b, .sfr_wr, .sfr_rd, .sfr_bit, .sfr_addr, .sfr_wdata,
		.sfr_bit_val, .sfr_rdata, .sfr_hit, .global_enable, .std_enable, .std_priority,
		.std_request, .vec_ack, .ret_ack, .irq_req, .irq_vector, .irq_source, .port_in,
		.port_out, .port_oe);
	xip_pins xip_pins_i (.port_out, .port_oe, .dev_low, .port_in);
	// ----
	// Helpers
	// ----
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One access: strobe held for exactly one sampling edge
	task automatic acc(input logic w, input logic r, input logic b, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge core_clk);
		sfr_wr <= w;
		sfr_rd <= r;
		sfr_bit <= b;
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_bit_val <= d[0];
		@(posedge core_clk);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
		sfr_bit <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, 1'b0, 1'b0, a, d);
	endtask
	task automatic bw(input logic [7:0] a, input logic v);
		acc(1'b1, 1'b0, 1'b1, a, {7'h0, v});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, 1'b1, 1'b0, a, 8'h00);
		chk(sfr_rdata, exp);
	endtask
	task automatic wreq(input logic e);
		int n;
		n = 0;
		while (irq_req !== e && n < 20) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(8'(irq_req), 8'(e));
	endtask
	// Vector and source are registered one cycle behind the request
	task automatic vec(input logic [7:0] v, input logic [7:0] s);
		@(posedge core_clk);
		#1;
		chk(irq_vector, v);
		chk(8'(irq_source), s);
	endtask
	task automatic pulse(input logic r);
		@(posedge core_clk);
		if (r)
			ret_ack <= 1'b1;
		else
			vec_ack <= 1'b1;
		@(posedge core_clk);
		vec_ack <= 1'b0;
		ret_ack <= 1'b0;
		#1;
	endtask
	task automatic pin(input logic [3:0] m);
		@(posedge core_clk);
		dev_low <= m;
		repeat (6) @(posedge core_clk);
		#1;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs;
		logic [7:0] m;
		m = 8'h00;
		rd(XIP_ADDR_XCTL, XIP_RESET_XCTL);
		rd(XIP_ADDR_PORT, 8'h0f);
		for (int i = 0; i < 8; i++) begin
			m[i] = 1'b1;
			bw(XIP_ADDR_XCTL + 8'(i), 1'b1);
			rd(XIP_ADDR_XCTL, m);
		end
		for (int i = 0; i < 8; i++) begin
			m[i] = 1'b0;
			bw(XIP_ADDR_XCTL + 8'(i), 1'b0);
			rd(XIP_ADDR_XCTL, m);
		end
		bw(8'hc2, 1'b1);
		rd(XIP_ADDR_XCTL, 8'h04);
		bw(8'hc6, 1'b1);
		rd(XIP_ADDR_XCTL, 8'h44);
		wr(8'ha0, 8'hff);
		rd(8'ha0, 8'h00);
		wr(XIP_ADDR_XCTL, 8'h00);
	endtask
	task automatic t_port;
		wr(XIP_ADDR_PORT, 8'h0a);
		pin(4'h0);
		rd(XIP_ADDR_PORT, 8'h0a);
		bw(8'hd8, 1'b1);
		bw(8'hd9, 1'b0);
		bw(8'hdc, 1'b0);
		chk({4'h0, port_out}, 8'h09);
		wr(XIP_ADDR_PORT, 8'h0f);
		pin(4'h8);
		rd(XIP_ADDR_PORT, 8'h07);
		pin(4'h0);
	endtask
	task automatic t_edge;
		@(posedge core_clk);
		global_enable <= 1'b1;
		wr(XIP_ADDR_XCTL, 8'h01);
		pin(4'h4);
		rd(XIP_ADDR_XCTL, 8'h03);
		chk(8'(irq_req), 8'h00);
		bw(8'hc2, 1'b1);
		wreq(1'b1);
		vec(8'h33, 8'h06);
		pulse(1'b0);
		rd(XIP_ADDR_XCTL, 8'h05);
		pin(4'h0);
		pulse(1'b1);
	endtask
	task automatic t_level;
		wr(XIP_ADDR_XCTL, 8'h40);
		pin(4'h8);
		wreq(1'b1);
		vec(8'h3b, 8'h07);
		rd(XIP_ADDR_XCTL, 8'h40);
		pulse(1'b0);
		pin(4'h0);
		pulse(1'b1);
		wreq(1'b0);
	endtask
	// Low std source in service must hold off a low extra A, not a high one
	task automatic t_prio;
		wr(XIP_ADDR_XCTL, 8'h05);
		@(posedge core_clk);
		std_enable <= 6'h01;
		std_request <= 6'h01;
		pin(4'h4);
		vec(8'h03, 8'h00);
		pulse(1'b0);
		@(posedge core_clk);
		std_request <= 6'h00;
		chk(8'(irq_req), 8'h00);
		bw(8'hc3, 1'b1);
		wreq(1'b1);
		vec(8'h33, 8'h06);
		pulse(1'b0);
		rd(XIP_ADDR_XCTL, 8'h0d);
		pulse(1'b1);
		pulse(1'b1);
		pin(4'h0);
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		t_regs();
		t_port();
		t_edge();
		t_level();
		t_prio();
		end_of_test();
	end
endmodule
bind xip_ctrl xip_props xip_props_i (.core_clk, .rst_b, .sfr_wr, .sfr_rd, .sfr_bit, .sfr_addr,
	.sfr_wdata, .sfr_bit_val, .sfr_rdata, .sfr_hit, .global_enable, .irq_req, .irq_vector,
	.irq_source, .port_out, .port_oe);

// ---- tb/xip_pins.sv ----
/* Far-side pins: pull-ups plus external devices pulling lines low.
   Assumes the bench sets dev_low for each pin a device holds low. */
`timescale 1ns/1ps
module xip_pins
(
	input wire logic [3:0] port_out,
	input wire logic [3:0] port_oe,
	input wire logic [3:0] dev_low,
	output logic [3:0] port_in
);
	assign port_in = ~((port_oe & ~port_out) | dev_low);
endmodule

// ---- tb/xip_props.sv ----
/* Port checker for xip_ctrl.
   Bound to the top by the testbench; watches only its ports. */
`timescale 1ns/1ps
module xip_props
	import xip_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic sfr_bit,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_bit_val,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic global_enable,
	input wire logic irq_req,
	input wire logic [7:0] irq_vector,
	input wire logic [2:0] irq_source,
	input wire logic [3:0] port_out,
	input wire logic [3:0] port_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ----
	// Decodes
	// ----
	wire mapped = (sfr_addr == XIP_ADDR_XCTL) || (sfr_addr == XIP_ADDR_PORT);
	wire port_bw = sfr_wr && sfr_bit && (sfr_addr[7:3] == XIP_ADDR_PORT[7:3]);
	// ----
	// Properties
	// ----
	AST_HIT: assert property (!sfr_bit |-> sfr_hit == mapped)
		else $error("byte decode wrong");
	AST_UNMAPPED: assert property (sfr_rd && !sfr_bit && !mapped |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RD_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without read");
	AST_VEC_MAP: assert property (irq_vector == XIP_VEC_EXT0 + {2'h0, irq_source, 3'h0})
		else $error("vector does not match source");
	AST_GLOBAL: assert property (!global_enable |-> !irq_req)
		else $error("request while globally disabled");
	AST_PORT_WR: assert property (sfr_wr && !sfr_bit && sfr_addr == XIP_ADDR_PORT
		|=> port_out == $past(sfr_wdata[3:0]))
		else $error("port byte write lost");
	AST_PORT_BIT: assert property (port_bw && !sfr_addr[2]
		|=> port_out[$past(sfr_addr[1:0])] == $past(sfr_bit_val))
		else $error("port bit write lost");
	AST_PORT_HI4: assert property (port_bw && sfr_addr[2] |=> $stable(port_out))
		else $error("pinless port bit changed latch");
	AST_OE_LOW: assert property ((~port_out & ~port_oe) == 4'h0)
		else $error("low latch not driven");
	AST_OE_REL: assert property ((port_oe & port_out & $past(port_out)) == 4'h0)
		else $error("high latch still driven");
	C_VEC_A: cover property (irq_req && irq_source == XIP_POS_A);
	C_VEC_B: cover property (irq_req && irq_source == XIP_POS_B);
	C_PORT_BIT: cover property (port_bw);
endmodule
